// [rtl/emdna_pkg.sv]
/*
 Constants and types for the external-master DRAM access sequencer (normal mode).
 Assumes a single bus clock; falling-edge events are modelled as half-cycle phase flags.
*/
package emdna_pkg;
	localparam int ADDR_W = 28;
	localparam int ROW_LSB = 9;
	localparam int LANES = 4;
	localparam int SYNC_STAGES = 2;
	// Port width codes for the decoded bank
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8 = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;
	// Size codes from the master
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;
	// Fastest row precharge: 1.5 clocks, counted in half clocks
	localparam int PRECHG_HALF_MIN = 3;
	localparam logic [3:0] PRECHG_HALF_RST = 4'h3;
	localparam logic [3:0] BEAT_CNT_RST = 4'h0;
	localparam logic [27:0] ADDR_RST = 28'h0000000;
	localparam logic [3:0] CAS_OFF = 4'hF;
	localparam logic [27:0] DRAM_BASE_RST = 28'h0000000;
	localparam logic [27:0] DRAM_MASK_RST = 28'hF000000;

	typedef enum logic [2:0] {
		EMDNA_IDLE, EMDNA_WAIT, EMDNA_ROW, EMDNA_COL, EMDNA_ACK, EMDNA_END, EMDNA_TAOFF
	} emdna_state_e;
endpackage

// [rtl/emdna_sync_if.sv]
/*
 Carrier between the top sequencer and its input synchroniser.
 Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ns
interface emdna_sync_if;
	logic [1:0] raw;
	logic [1:0] synced;
	modport src (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

// [rtl/emdna_sync.sv]
/*
 Two-flop synchroniser for asynchronous level inputs.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module emdna_sync
	import emdna_pkg::*;
(
	input wire logic CLK, // Bus clock
	input wire logic RST_N, // Async reset, active low
	emdna_sync_if.sync port // Raw in, synced out
);
	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
	} emdna_sync_s;
	emdna_sync_s s_reg;
	emdna_sync_s s_next;

	always_comb begin
		s_next.stage1 = port.raw;
		s_next.stage2 = s_reg.stage1;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// Resets to the idle level: the start strobe is active low, and a busy
			// refresh seen for two clocks only delays the next row drive
			s_reg <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign port.synced = s_reg.stage2;
endmodule

// [rtl/emdna_ctrl.sv]
/*
 External-master DRAM access sequencer, normal (non-page) mode, row strobe re-driven each beat: captures a master's
 request, decodes it against one DRAM bank, and drives row/column address,
 row/column strobes, write strobe and the transfer acknowledge.
 Assumes one bus clock; falling-edge strobe events are produced by half-cycle
 flops on the negative edge fed only from rising-edge state.
*/
`timescale 1ns/1ns
module emdna_ctrl
	import emdna_pkg::*;
(
	input wire logic CLK, // Bus clock
	input wire logic RST_N, // Async reset, active low
	input wire logic TRANSFER_START_N, // Start strobe from master pin
	input wire logic [27:0] ADDR_IN, // Address from master
	input wire logic READ_NWRITE, // Direction, high for read
	input wire logic [1:0] XFER_SIZE_CODE, // Operand size code
	input wire logic EXT_ADDR_MUX_ENABLE, // Drive address lines when set
	input wire logic [27:0] DRAM_BASE, // Bank base address
	input wire logic [27:0] DRAM_MASK, // Bank mask, set bits ignored
	input wire logic [1:0] PORT_WIDTH, // Bank port width code
	input wire logic [3:0] PRECHG_HALF, // Row precharge in half clocks, min 3
	input wire logic [1:0] BANK_COL_SHIFT, // Column bits shift selector
	input wire logic REFRESH_BUSY, // Refresh running or pending
	output logic [27:0] ADDR_OUT, // Address drive value
	output logic ADDR_OE, // Address output enable
	output logic RAS_N, // Row strobe
	output logic [3:0] CAS_N, // Column strobes per lane
	output logic DRAM_WRITE_STROBE_N, // DRAM write strobe
	output logic TRANSFER_ACK_N_O, // Acknowledge drive value
	output logic TRANSFER_ACK_OE, // Acknowledge output enable
	output logic REFRESH_HOLD // Asks refresh to wait
);
	typedef struct packed {
		emdna_state_e state;
		logic [27:0] addr;
		logic rd;
		logic [1:0] size;
		logic [3:0] beats_left;
		logic [3:0] pre_cnt;
		logic [27:0] aout;
		logic aoe;
		logic ras_rise;
		logic cas_rise;
		logic [3:0] lanes;
		logic we_n;
		logic ta_n;
		logic ta_oe;
		logic hold;
		logic [1:0] col_shift;
	} emdna_ctrl_s;
	emdna_ctrl_s s_reg;
	emdna_ctrl_s s_next;
	logic ras_fall_reg;
	logic [3:0] cas_fall_reg;

	emdna_sync_if sif();
	logic ts_n_s;
	logic refresh_s;
	assign sif.raw = {TRANSFER_START_N, REFRESH_BUSY};
	assign ts_n_s = sif.synced[1];
	assign refresh_s = sif.synced[0];

	emdna_sync u_sync (
		.CLK(CLK),
		.RST_N(RST_N),
		.port(sif.sync)
	);

	function automatic logic [3:0] beat_count(input logic [1:0] sz, input logic [1:0] pw);
		logic [3:0] bytes;
		logic [3:0] per;
		bytes = (sz == SIZE_BYTE) ? 4'h1 : (sz == SIZE_WORD) ? 4'h2 : 4'h4;
		per = (pw == PORT_8) ? 4'h1 : (pw == PORT_16) ? 4'h2 : 4'h4;
		if (sz == SIZE_LINE) begin
			beat_count = (pw == PORT_32) ? 4'h4 : (pw == PORT_16) ? 4'h8 : 4'hF;
		end else begin
			beat_count = (bytes > per) ? (bytes / per) : 4'h1;
		end
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic [1:0] pw);
		if (pw == PORT_8 || sz == SIZE_BYTE) begin
			lane_mask = 4'h1;
		end else if (pw == PORT_16 || sz == SIZE_WORD) begin
			lane_mask = 4'h3;
		end else begin
			lane_mask = 4'hF;
		end
	endfunction

	logic hit;
	logic [3:0] pre_min;
	logic [27:0] col_addr;
	logic [27:0] step;
	always_comb begin
		hit = ((ADDR_IN ^ DRAM_BASE) & ~DRAM_MASK) == 28'h0000000;
		pre_min = (PRECHG_HALF < PRECHG_HALF_RST) ? PRECHG_HALF_RST : PRECHG_HALF;
		col_addr = s_reg.addr;
		col_addr[27:ROW_LSB] = s_reg.addr[27:ROW_LSB] >> (5'h8 + {3'h0, s_reg.col_shift});
		step = (s_reg.size == SIZE_BYTE || PORT_WIDTH == PORT_8) ? 28'h0000001 :
			(PORT_WIDTH == PORT_16) ? 28'h0000002 : 28'h0000004;
	end

	always_comb begin
		s_next = s_reg;
		s_next.pre_cnt = (s_reg.pre_cnt != 4'h0) ? s_reg.pre_cnt - 4'h1 : 4'h0;
		s_next.ras_rise = 1'b1;
		s_next.cas_rise = 1'b1;
		case (s_reg.state)
			EMDNA_IDLE: begin
				s_next.ta_oe = 1'b0;
				if (!ts_n_s) begin
					s_next.addr = ADDR_IN;
					s_next.rd = READ_NWRITE;
					s_next.size = XFER_SIZE_CODE;
					s_next.col_shift = BANK_COL_SHIFT;
					s_next.beats_left = beat_count(XFER_SIZE_CODE, PORT_WIDTH) - 4'h1;
					s_next.lanes = lane_mask(XFER_SIZE_CODE, PORT_WIDTH);
					if (hit) begin
						s_next.state = EMDNA_WAIT;
						s_next.hold = 1'b1;
					end
				end
			end
			EMDNA_WAIT: begin
				// Row strobe lands half a clock after this edge, so the count runs in
				// whole clocks and one left still gives the full precharge
				if (!refresh_s && s_reg.pre_cnt <= 4'h1) begin
					s_next.state = EMDNA_ROW;
					s_next.ras_rise = 1'b0;
					s_next.aout = s_reg.addr;
					s_next.aoe = EXT_ADDR_MUX_ENABLE;
					s_next.we_n = s_reg.rd;
				end
			end
			EMDNA_ROW: begin
				s_next.ras_rise = 1'b0;
				s_next.cas_rise = 1'b0;
				s_next.state = EMDNA_COL;
				s_next.aout = col_addr;
				s_next.ta_n = 1'b1;
				s_next.ta_oe = 1'b1;
			end
			EMDNA_COL: begin
				s_next.ras_rise = 1'b0;
				s_next.cas_rise = 1'b0;
				s_next.state = EMDNA_ACK;
				s_next.ta_n = 1'b0;
			end
			EMDNA_ACK: begin
				s_next.ta_n = 1'b1;
				s_next.pre_cnt = {1'b0, pre_min[3:1]};
				s_next.we_n = 1'b1;
				if (s_reg.beats_left != 4'h0) begin
					s_next.beats_left = s_reg.beats_left - 4'h1;
					s_next.addr = s_reg.addr + step;
					s_next.aout = s_reg.addr + step;
					s_next.we_n = s_reg.rd;
					s_next.state = EMDNA_END;
				end else begin
					s_next.aoe = 1'b0;
					s_next.hold = 1'b0;
					s_next.state = EMDNA_TAOFF;
				end
			end
			EMDNA_END: begin
				// Secondary beat: row already driven, wait out precharge
				if (s_reg.pre_cnt <= 4'h1) begin
					s_next.state = EMDNA_ROW;
					s_next.ras_rise = 1'b0;
				end
			end
			EMDNA_TAOFF: begin
				s_next.ta_oe = 1'b0;
				s_next.state = EMDNA_IDLE;
			end
			default: begin
				s_next.state = EMDNA_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg.state <= EMDNA_IDLE;
			s_reg.addr <= ADDR_RST;
			s_reg.rd <= 1'b1;
			s_reg.size <= SIZE_LONG;
			s_reg.beats_left <= BEAT_CNT_RST;
			s_reg.pre_cnt <= 4'h0;
			s_reg.aout <= ADDR_RST;
			s_reg.aoe <= 1'b0;
			s_reg.ras_rise <= 1'b1;
			s_reg.cas_rise <= 1'b1;
			s_reg.lanes <= 4'h0;
			s_reg.we_n <= 1'b1;
			s_reg.ta_n <= 1'b1;
			s_reg.ta_oe <= 1'b0;
			s_reg.hold <= 1'b0;
			s_reg.col_shift <= 2'h0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Strobes assert on the falling edge after the rising-edge decision and
	// negate on the rising edge, so each is the OR of two flops' states.
	always_ff @(negedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ras_fall_reg <= 1'b1;
			cas_fall_reg <= CAS_OFF;
		end else begin
			ras_fall_reg <= s_reg.ras_rise;
			cas_fall_reg <= s_reg.cas_rise ? CAS_OFF : ~s_reg.lanes;
		end
	end

	always_comb begin
		ADDR_OUT = s_reg.aout;
		ADDR_OE = s_reg.aoe;
		RAS_N = ras_fall_reg | s_reg.ras_rise;
		CAS_N = cas_fall_reg | {LANES{s_reg.cas_rise}};
		DRAM_WRITE_STROBE_N = s_reg.we_n;
		TRANSFER_ACK_N_O = s_reg.ta_n;
		TRANSFER_ACK_OE = s_reg.ta_oe;
		REFRESH_HOLD = s_reg.hold;
	end
endmodule

// [verif/emdna_ctrl_assertions.sv]
/* Checker for the DRAM sequencer pins: strobe order, acknowledge, release.
 Assumes it is bound to emdna_ctrl and sees only its ports. */
`timescale 1ns/1ns
module emdna_chk
	import emdna_pkg::*;
(
	input wire logic CLK, // Clock
	input wire logic RST_N, // Reset
	input wire logic EXT_ADDR_MUX_ENABLE, // Mux on
	input wire logic [3:0] PRECHG_HALF, // Precharge
	input wire logic ADDR_OE, // Addr enable
	input wire logic RAS_N, // Row strobe
	input wire logic [3:0] CAS_N, // Col strobes
	input wire logic TRANSFER_ACK_N_O, // Ack
	input wire logic TRANSFER_ACK_OE, // Ack enable
	input wire logic REFRESH_HOLD // Hold
);
	logic [7:0] hi_cnt;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Saturates so the long idle after reset never looks like a short precharge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			hi_cnt <= 8'hFF;
		else if (!RAS_N)
			hi_cnt <= 8'h00;
		else if (hi_cnt != 8'hFF)
			hi_cnt <= hi_cnt + 8'h01;
	end
	sequence row_s;
		!RAS_N && CAS_N == CAS_OFF;
	endsequence
	sequence col_s;
		!RAS_N && CAS_N != CAS_OFF && TRANSFER_ACK_OE && TRANSFER_ACK_N_O ##1
		!RAS_N && !TRANSFER_ACK_N_O ##1 RAS_N && CAS_N == CAS_OFF && TRANSFER_ACK_N_O;
	endsequence
	beat_order_a: assert property ($fell(RAS_N) |-> row_s ##1 col_s)
		else $error("beat strobe order");
	ack_cas_a: assert property (!TRANSFER_ACK_N_O && TRANSFER_ACK_OE |->
		CAS_N != CAS_OFF && $past(CAS_N) != CAS_OFF) else $error("ack without cas");
	cas_ras_a: assert property (CAS_N != CAS_OFF |-> !RAS_N)
		else $error("cas without ras");
	ack_drive_a: assert property ($rose(TRANSFER_ACK_OE) |->
		TRANSFER_ACK_N_O && !RAS_N ##1 !TRANSFER_ACK_N_O) else $error("ack drive");
	ack_release_a: assert property ($fell(TRANSFER_ACK_OE) |->
		RAS_N && $past(TRANSFER_ACK_N_O, 2) == 1'b0) else $error("ack release");
	addr_release_a: assert property ($fell(ADDR_OE) |->
		RAS_N && !$past(TRANSFER_ACK_N_O)) else $error("addr release");
	mux_off_a: assert property (!EXT_ADDR_MUX_ENABLE |-> !ADDR_OE)
		else $error("addr driven");
	precharge_a: assert property ($fell(RAS_N) |->
		hi_cnt >= {5'h00, PRECHG_HALF[3:1]}) else $error("short precharge");
	refresh_hold_a: assert property (!RAS_N |-> REFRESH_HOLD)
		else $error("no refresh hold");
endmodule
bind emdna_ctrl emdna_chk chk_u (.CLK(CLK), .RST_N(RST_N),
	.EXT_ADDR_MUX_ENABLE(EXT_ADDR_MUX_ENABLE), .PRECHG_HALF(PRECHG_HALF),
	.ADDR_OE(ADDR_OE), .RAS_N(RAS_N), .CAS_N(CAS_N), .TRANSFER_ACK_N_O(TRANSFER_ACK_N_O),
	.TRANSFER_ACK_OE(TRANSFER_ACK_OE), .REFRESH_HOLD(REFRESH_HOLD));

// [verif/emdna_master.sv]
/* External bus master model: starts one transfer per call.
 Assumes the caller waits for the acknowledge release before calling again. */
`timescale 1ns/1ns
module emdna_master
	import emdna_pkg::*;
(
	input wire logic CLK, // Clock
	output logic TRANSFER_START_N, // Start
	output logic [27:0] ADDR_IN, // Address
	output logic READ_NWRITE, // Direction
	output logic [1:0] XFER_SIZE_CODE // Size
);
	initial begin
		TRANSFER_START_N = 1'b1;
		ADDR_IN = 28'h0000000;
		READ_NWRITE = 1'b1;
		XFER_SIZE_CODE = SIZE_LONG;
	end
	task automatic xfer(input logic [27:0] a, input logic r, input logic [1:0] s);
		@(posedge CLK);
		#1;
		ADDR_IN = a;
		READ_NWRITE = r;
		XFER_SIZE_CODE = s;
		TRANSFER_START_N = 1'b0;
		@(posedge CLK);
		#1;
		TRANSFER_START_N = 1'b1;
		// The strobe crosses two sync flops, so the address outlives it
		repeat (3) @(posedge CLK);
		#1;
		ADDR_IN = ~a; // Released bus shows no stale value
	endtask
endmodule

// [verif/emdna_ctrl_tb.sv]
/* Self-checking bench for emdna_ctrl against a beat model.
 Assumes the master model and the bound checker. */
`timescale 1ns/1ns
module emdna_ctrl_tb;
	import emdna_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, mux = 1'b1, rfsh = 1'b0, ts_n, rw;
	logic aoe, ras_n, we_n, ta_n, ta_oe, hold;
	logic [1:0] pw = PORT_32, sh = 2'h0, sz;
	logic [3:0] pre = 4'h3, cas_n;
	logic [27:0] ain, aout;
	logic [1:0] s_tbl [8] = '{SIZE_LONG, SIZE_LINE, SIZE_BYTE, SIZE_WORD,
		SIZE_LONG, SIZE_BYTE, SIZE_WORD, SIZE_LONG};
	logic [1:0] p_tbl [8] = '{PORT_32, PORT_32, PORT_16, PORT_16, PORT_16, PORT_8, PORT_8, PORT_8};
	int error_cnt = 0, total_checks = 0;
	always #5 clk = ~clk;
	emdna_master mst_u (.CLK(clk), .TRANSFER_START_N(ts_n), .ADDR_IN(ain),
		.READ_NWRITE(rw), .XFER_SIZE_CODE(sz));
	emdna_ctrl dut_u (.CLK(clk), .RST_N(rst_n), .TRANSFER_START_N(ts_n), .ADDR_IN(ain),
		.READ_NWRITE(rw), .XFER_SIZE_CODE(sz), .EXT_ADDR_MUX_ENABLE(mux),
		.DRAM_BASE(28'h0000000), .DRAM_MASK(28'h0FFFFFF), .PORT_WIDTH(pw),
		.PRECHG_HALF(pre), .BANK_COL_SHIFT(sh), .REFRESH_BUSY(rfsh), .ADDR_OUT(aout),
		.ADDR_OE(aoe), .RAS_N(ras_n), .CAS_N(cas_n), .DRAM_WRITE_STROBE_N(we_n),
		.TRANSFER_ACK_N_O(ta_n), .TRANSFER_ACK_OE(ta_oe), .REFRESH_HOLD(hold));
	task automatic chk(input logic [27:0] g, input logic [27:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_n(input int g, input int e);
		total_checks++;
		if (g != e) begin
			error_cnt++;
			$display("wrong value at %0t: count %0d not %0d", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Samples just after each falling edge, where row and ack phases are settled
	task automatic run(input logic [27:0] a, input logic r, input logic [1:0] s, input int lim);
		int pb, ob, n, k, c, lc;
		logic pr;
		logic [3:0] ec;
		logic [27:0] ra;
		pb = pw == PORT_32 ? 4 : pw == PORT_8 ? 1 : 2;
		ob = s == SIZE_LONG ? 4 : s == SIZE_BYTE ? 1 : s == SIZE_WORD ? 2 : 16;
		n = a[27:24] != 4'h0 ? 0 : ob > pb ? ob / pb : 1;
		ec = ~4'((1 << (ob < pb ? ob : pb)) - 1);
		k = 0;
		lc = 0;
		pr = 1'b1;
		fork
			mst_u.xfer(a, r, s);
		join_none
		for (c = 0; c < lim && !(k > 0 && ta_oe === 1'b0); c++) begin
			@(negedge clk);
			#2;
			if (pr && ras_n === 1'b0) begin
				chk(28'(aoe), 28'(mux));
				chk(mux ? aout : 28'h0, mux ? a + 28'(k * pb) : 28'h0);
				chk(28'({we_n, rfsh}), 28'({r, 1'b0}));
			end
			if (ta_n === 1'b0 && ta_oe === 1'b1) begin
				chk(28'(cas_n), 28'(ec));
				ra = a + 28'(k * pb);
				chk(mux ? aout : 28'h0, mux ? {19'(ra[27:9] >> (8 + sh)), ra[8:0]} : 28'h0);
				if (k > 0 && pre == 4'h3)
					chk_n(c - lc, 4);
				lc = c;
				k++;
			end
			pr = ras_n;
		end
		chk_n(k, n);
		if (n > 0)
			chk_n(int'(c < lim), 1);
	endtask
	initial begin
		int i;
		void'($urandom(32'h95fd9e1a));
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			#1;
			pw = p_tbl[i % 8];
			pre = 4'(3 + $urandom % 4);
			sh = 2'($urandom);
			mux = (i % 4) != 3;
			run({4'h0, 24'($urandom)} & ~28'hF, i[3], s_tbl[i % 8], 300);
		end
		run(28'h1000040, 1'b0, SIZE_LONG, 20);
		@(posedge clk);
		#1;
		rfsh = 1'b1;
		fork
			begin
				repeat (15) @(posedge clk);
				#1;
				rfsh = 1'b0;
			end
		join_none
		run(28'h0000100, 1'b0, SIZE_LONG, 300);
		fork
			mst_u.xfer(28'h0000200, 1'b1, SIZE_WORD);
		join_none
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b0;
		#2;
		chk(28'({aoe, ras_n, cas_n, we_n, ta_oe}), 28'h000007E);
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		pw = PORT_32;
		mux = 1'b1;
		run(28'h0000300, 1'b1, SIZE_LINE, 300);
		give_verdict;
	end
	initial begin
		#500000;
		error_cnt++;
		give_verdict;
	end
endmodule
